// ---- hdl/mdrm_regmap.sv ----
/*
 * register map of the drive as seen by the serial master: command and
 * reference registers, status and monitor reads, sticky link errors and
 * a pending parameter area moved to ram alone or to ram and the non-volatile copy on commit.
 * assumes the link logic hands over one register per request, on this clock,
 * after address filtering, and frames any answer itself.
 */
`timescale 1ns/100ps
module mdrm_regmap #(
  parameter int          PARAM_DEPTH = 16,      // parameter words behind the map
  parameter logic [15:0] PART_ID1    = 16'h0000, // arbitrary identity value
  parameter logic [15:0] PART_ID2    = 16'h0000  // arbitrary identity value
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  input  wire logic                  REQ_VALID_I,
  input  wire logic [7:0]            REQ_SLAVE_I,
  input  wire logic [7:0]            REQ_FUNC_I,
  input  wire logic [15:0]           REQ_ADDR_I,
  input  wire logic [15:0]           REQ_WDATA_I,
  input  wire mdrm_pkg::mdrm_status_t STATUS_I,
  input  wire mdrm_pkg::mdrm_pins_t  PINS_I,
  input  wire mdrm_pkg::mdrm_mon_t   MON_I,
  input  wire mdrm_pkg::mdrm_lerr_t  LINK_ERR_I,
  input  wire logic                  FAULT_RESET_I,
  input  wire logic [7:0]            PARAM_SEL_I,
  output logic                       RSP_VALID_O,
  output logic                       RSP_EXC_O,
  output logic [7:0]                 RSP_CODE_O,
  output logic [15:0]                RSP_DATA_O,
  output mdrm_pkg::mdrm_cmd_t        CMD_O,
  output logic [15:0]                SPEED_REF_O,
  output logic                       NV_SAVE_O,
  output logic [15:0]                PARAM_ACT_O,
  output logic [15:0]                PARAM_NV_O
);
  localparam int IW = $clog2(PARAM_DEPTH);

  logic                          rst_q1, rst_n;     // reset release synchroniser
  logic [15:0]                   cmd_reg, ref_reg;  // broadcast registers
  logic [15:0]                   lerr_reg;          // sticky link errors
  logic [PARAM_DEPTH-1:0][15:0]  pend_reg;          // written, not yet active
  logic [PARAM_DEPTH-1:0][15:0]  act_reg;           // active ram copy
  logic [PARAM_DEPTH-1:0][15:0]  nv_reg;            // non-volatile copy
  logic                          rsp_valid_reg, rsp_exc_reg, nv_save_reg;
  logic [7:0]                    rsp_code_reg;
  logic [15:0]                   rsp_data_reg;
  logic                          frst_q;            // previous fault reset level

  // request decode terms
  logic                          bcast, is_rd, is_wr, is_loop, in_par;
  logic [15:0]                   par_off;
  logic [IW-1:0]                 par_idx;
  logic                          wr_cmd, wr_ref, wr_par, commit_nv, commit_ram;
  logic [7:0]                    err_code;
  logic [15:0]                   rd_word;
  logic                          fault_clear;
  logic [15:0]                   lerr_set;

  // reset is asserted at once and released through two flops
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  assign bcast   = (REQ_SLAVE_I == mdrm_pkg::BCAST_ADDR);
  assign is_rd   = (REQ_FUNC_I == mdrm_pkg::FN_READ);
  assign is_wr   = (REQ_FUNC_I == mdrm_pkg::FN_WRITE);
  assign is_loop = (REQ_FUNC_I == mdrm_pkg::FN_LOOP);
  assign par_off = REQ_ADDR_I - mdrm_pkg::A_PARAM_BASE;
  assign in_par  = (REQ_ADDR_I >= mdrm_pkg::A_PARAM_BASE) && (par_off < 16'(PARAM_DEPTH));
  assign par_idx = par_off[IW-1:0];

  // read mux; reserved bits come back zero, reserved addresses are refused with 02H
  always_comb begin
    rd_word = mdrm_pkg::RESET_WORD;
    case (REQ_ADDR_I)
      mdrm_pkg::A_CMD:      rd_word = cmd_reg;
      mdrm_pkg::A_REF:      rd_word = ref_reg;
      mdrm_pkg::A_STATE:    rd_word = STATUS_I;
      mdrm_pkg::A_PINS: begin
        rd_word[2:0] = {PINS_I.photocoupler_output_2, PINS_I.photocoupler_output_1,
                        PINS_I.relay_contact_output};
        rd_word[mdrm_pkg::PIN_FAULT] = PINS_I.fault_contact;
      end
      mdrm_pkg::A_BIAS:     rd_word = MON_I.bias;
      mdrm_pkg::A_VBUS:     rd_word = MON_I.vbus;
      mdrm_pkg::A_TORQ:     rd_word = MON_I.torque;
      mdrm_pkg::A_ID1:      rd_word = PART_ID1;
      mdrm_pkg::A_ID2:      rd_word = PART_ID2;
      mdrm_pkg::A_LOOP_U:   rd_word = MON_I.loop_u;
      mdrm_pkg::A_LOOP_S:   rd_word = MON_I.loop_s;
      mdrm_pkg::A_LOOP_OUT: rd_word = MON_I.loop_out;
      mdrm_pkg::A_LINK_ERR: rd_word = lerr_reg;
      mdrm_pkg::A_RPM:      rd_word = MON_I.rpm;
      mdrm_pkg::A_PCT:      rd_word = MON_I.pct;
      default: begin
        if (in_par) begin
          rd_word = act_reg[par_idx];
        end
      end
    endcase
  end

  // error code and write strobes for the request in hand
  always_comb begin
    err_code   = 8'h00;
    wr_cmd     = 1'b0;
    wr_ref     = 1'b0;
    wr_par     = 1'b0;
    commit_nv  = 1'b0;
    commit_ram = 1'b0;
    if (!(is_rd || is_wr || is_loop)) begin
      err_code = mdrm_pkg::EC_FUNC;
    end else if (is_rd) begin
      case (REQ_ADDR_I)
        // write-only commit registers have no readable contents
        mdrm_pkg::A_COMMIT_NV, mdrm_pkg::A_COMMIT_RAM: err_code = mdrm_pkg::EC_REG;
        mdrm_pkg::A_CMD, mdrm_pkg::A_REF, mdrm_pkg::A_STATE, mdrm_pkg::A_PINS,
        mdrm_pkg::A_BIAS, mdrm_pkg::A_VBUS, mdrm_pkg::A_TORQ, mdrm_pkg::A_ID1,
        mdrm_pkg::A_ID2, mdrm_pkg::A_LOOP_U, mdrm_pkg::A_LOOP_S, mdrm_pkg::A_LOOP_OUT,
        mdrm_pkg::A_LINK_ERR, mdrm_pkg::A_RPM, mdrm_pkg::A_PCT: err_code = 8'h00;
        default: err_code = in_par ? 8'h00 : mdrm_pkg::EC_REG;
      endcase
    end else if (is_wr) begin
      case (REQ_ADDR_I)
        mdrm_pkg::A_CMD: wr_cmd = 1'b1;
        mdrm_pkg::A_REF: wr_ref = 1'b1;
        mdrm_pkg::A_COMMIT_NV, mdrm_pkg::A_COMMIT_RAM: begin
          if (bcast) begin
            err_code = mdrm_pkg::EC_REG;
          end else if (REQ_WDATA_I != mdrm_pkg::COMMIT_VALUE) begin
            err_code = mdrm_pkg::EC_DATA;
          end else if (REQ_ADDR_I == mdrm_pkg::A_COMMIT_NV) begin
            commit_nv = 1'b1;
          end else begin
            commit_ram = 1'b1;
          end
        end
        mdrm_pkg::A_STATE, mdrm_pkg::A_PINS, mdrm_pkg::A_BIAS, mdrm_pkg::A_VBUS,
        mdrm_pkg::A_TORQ, mdrm_pkg::A_ID1, mdrm_pkg::A_ID2, mdrm_pkg::A_LOOP_U,
        mdrm_pkg::A_LOOP_S, mdrm_pkg::A_LOOP_OUT, mdrm_pkg::A_LINK_ERR,
        mdrm_pkg::A_RPM, mdrm_pkg::A_PCT: err_code = mdrm_pkg::EC_MODE;
        default: begin
          // a broadcast may only reach the command and reference words
          if (in_par && !bcast) begin
            wr_par = 1'b1;
          end else begin
            err_code = mdrm_pkg::EC_REG;
          end
        end
      endcase
    end
  end

  // command and reference words take effect straight away
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= mdrm_pkg::RESET_WORD;
      ref_reg <= mdrm_pkg::RESET_WORD;
    end else if (REQ_VALID_I) begin
      if (wr_cmd) begin
        cmd_reg <= REQ_WDATA_I & mdrm_pkg::CMD_MASK;
      end
      if (wr_ref) begin
        ref_reg <= REQ_WDATA_I;
      end
    end
  end

  // command levels: the struct is written from one process only
  always_comb begin
    CMD_O.run         = cmd_reg[mdrm_pkg::B_RUN];
    CMD_O.reverse     = cmd_reg[mdrm_pkg::B_REV];
    CMD_O.ext_fault   = cmd_reg[mdrm_pkg::B_EXTF];
    CMD_O.fault_reset = cmd_reg[mdrm_pkg::B_FRST];
    CMD_O.contact_in  = cmd_reg[mdrm_pkg::B_CI5 +: 3];
  end
  assign SPEED_REF_O       = ref_reg;

  // fault reset is the rising edge of the command bit or the drive's own reset
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      frst_q <= 1'b0;
    end else begin
      frst_q <= cmd_reg[mdrm_pkg::B_FRST];
    end
  end
  assign fault_clear = FAULT_RESET_I || (cmd_reg[mdrm_pkg::B_FRST] && !frst_q);

  assign lerr_set = {9'h000, LINK_ERR_I.timeout, LINK_ERR_I.framing, LINK_ERR_I.overrun,
                     LINK_ERR_I.parity, 1'b0, LINK_ERR_I.length, LINK_ERR_I.crc};

  // sticky link errors; an event in the clearing cycle survives the clear
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lerr_reg <= mdrm_pkg::RESET_WORD;
    end else if (fault_clear) begin
      lerr_reg <= lerr_set & mdrm_pkg::LINK_ERR_MASK;
    end else begin
      lerr_reg <= (lerr_reg | lerr_set) & mdrm_pkg::LINK_ERR_MASK;
    end
  end

  // one pending, active and non-volatile word per parameter entry
  for (genvar g = 0; g < PARAM_DEPTH; g++) begin : g_par
    always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        pend_reg[g] <= mdrm_pkg::RESET_WORD;
      end else if (REQ_VALID_I && wr_par && par_idx == IW'(g)) begin
        pend_reg[g] <= REQ_WDATA_I;
      end
    end
    // active copy only follows pending on a commit of either kind
    always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        act_reg[g] <= mdrm_pkg::RESET_WORD;
      end else if (REQ_VALID_I && (commit_nv || commit_ram)) begin
        act_reg[g] <= pend_reg[g];
      end
    end
    // the non-volatile copy wears out, so only the saving commit touches it
    always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        nv_reg[g] <= mdrm_pkg::RESET_WORD;
      end else if (REQ_VALID_I && commit_nv) begin
        nv_reg[g] <= pend_reg[g];
      end
    end
  end

  // answer one cycle after the request; broadcasts stay silent
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_exc_reg   <= 1'b0;
      rsp_code_reg  <= 8'h00;
      rsp_data_reg  <= mdrm_pkg::RESET_WORD;
      nv_save_reg   <= 1'b0;
    end else begin
      rsp_valid_reg <= REQ_VALID_I && !bcast;
      nv_save_reg   <= REQ_VALID_I && commit_nv;
      if (REQ_VALID_I) begin
        rsp_exc_reg  <= (err_code != 8'h00);
        rsp_code_reg <= err_code;
        rsp_data_reg <= is_loop ? REQ_WDATA_I :
                        (is_rd && err_code == 8'h00) ? rd_word : REQ_WDATA_I;
      end
    end
  end

  assign RSP_VALID_O = rsp_valid_reg;
  assign RSP_EXC_O   = rsp_exc_reg;
  assign RSP_CODE_O  = rsp_code_reg;
  assign RSP_DATA_O  = rsp_data_reg;
  assign NV_SAVE_O   = nv_save_reg;
  assign PARAM_ACT_O = (PARAM_SEL_I < 8'(PARAM_DEPTH)) ? act_reg[PARAM_SEL_I[IW-1:0]] : 16'h0000;
  assign PARAM_NV_O  = (PARAM_SEL_I < 8'(PARAM_DEPTH)) ? nv_reg[PARAM_SEL_I[IW-1:0]] : 16'h0000;

  // a broadcast never produces an answer
  a_bcast_silent: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && bcast |=> !RSP_VALID_O)
    else $error("broadcast answered");

  // command bits follow the written word on the next cycle
  a_cmd_run: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && wr_cmd |=> CMD_O.run == $past(REQ_WDATA_I[0]))
    else $error("run bit wrong");
  a_cmd_dir: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && wr_cmd |=> CMD_O.reverse == $past(REQ_WDATA_I[1]))
    else $error("direction bit wrong");
  a_cmd_faults: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && wr_cmd |=> {CMD_O.fault_reset, CMD_O.ext_fault} == $past(REQ_WDATA_I[5:4]))
    else $error("fault bits wrong");
  a_cmd_contacts: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && wr_cmd |=> CMD_O.contact_in == $past(REQ_WDATA_I[14:12]))
    else $error("contact bits wrong");

  // pending writes leave the active copy alone
  a_pend_hold: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && wr_par |=> $stable(act_reg) && $stable(nv_reg))
    else $error("pending write leaked");

  // saving commit copies pending into both copies
  a_commit_nv: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && commit_nv |=> act_reg == $past(pend_reg) && nv_reg == $past(pend_reg)
    && NV_SAVE_O)
    else $error("save commit wrong");

  // ram commit leaves the non-volatile copy untouched
  a_commit_ram: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && commit_ram |=> act_reg == $past(pend_reg) && $stable(nv_reg) && !NV_SAVE_O)
    else $error("ram commit wrong");

  // reading a commit register is refused with 02H
  a_commit_read: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && is_rd &&
    (REQ_ADDR_I == mdrm_pkg::A_COMMIT_NV || REQ_ADDR_I == mdrm_pkg::A_COMMIT_RAM)
    |=> RSP_VALID_O && RSP_EXC_O && RSP_CODE_O == mdrm_pkg::EC_REG)
    else $error("commit read accepted");

  // a latched link error holds until a fault reset
  a_lerr_sticky: assert property (@(posedge CLK_I) disable iff (!rst_n)
    LINK_ERR_I.crc ##1 !fault_clear [*2] |=> lerr_reg[0])
    else $error("crc flag lost");

  // status word is returned bit for bit
  a_status_read: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && is_rd && REQ_ADDR_I == mdrm_pkg::A_STATE
    |=> RSP_DATA_O == $past(STATUS_I) && !RSP_EXC_O)
    else $error("status read wrong");

  // unknown functions are refused with 01H
  a_func_err: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && !(is_rd || is_wr || is_loop)
    |=> RSP_EXC_O && RSP_CODE_O == mdrm_pkg::EC_FUNC)
    else $error("bad function accepted");

  // every unicast request is answered a cycle later
  a_unicast_answer: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast |=> RSP_VALID_O)
    else $error("request unanswered");

  // a reference write shows on the output next cycle
  a_ref_write: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && wr_ref |=> SPEED_REF_O == $past(REQ_WDATA_I))
    else $error("reference write lost");

  // undefined command bits never store
  a_cmd_mask: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && wr_cmd |=> (cmd_reg & ~mdrm_pkg::CMD_MASK) == mdrm_pkg::RESET_WORD)
    else $error("reserved command bit stored");

  // a refused write changes no stored word
  a_refused_write: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && is_wr && err_code != 8'h00 |=> $stable(cmd_reg) && $stable(ref_reg)
    && $stable(pend_reg))
    else $error("refused write stored");

  // a fault reset with no new event empties the error word
  a_lerr_clear: assert property (@(posedge CLK_I) disable iff (!rst_n)
    fault_clear && lerr_set == mdrm_pkg::RESET_WORD |=> lerr_reg == mdrm_pkg::RESET_WORD)
    else $error("link errors not cleared");

  // pin word: outputs in bits 2..0, fault contact at bit 7, rest zero
  a_pins_read: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && is_rd && REQ_ADDR_I == mdrm_pkg::A_PINS |=> RSP_DATA_O ==
    {8'h00, $past(PINS_I.fault_contact), 4'h0, $past(PINS_I.photocoupler_output_2),
     $past(PINS_I.photocoupler_output_1), $past(PINS_I.relay_contact_output)})
    else $error("pin word wrong");

  // keypad source flags sit at bits 9 and A of the status answer
  a_keypad_bits: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && is_rd && REQ_ADDR_I == mdrm_pkg::A_STATE
    |=> RSP_DATA_O[10:9] == $past({STATUS_I.keypad_run, STATUS_I.keypad_ref}))
    else $error("keypad bits wrong");

  // loop monitors pass through as given; scaling is the drive's job
  a_loop_u_read: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && is_rd && REQ_ADDR_I == mdrm_pkg::A_LOOP_U
    |=> RSP_DATA_O == $past(MON_I.loop_u))
    else $error("unsigned monitor wrong");

  a_loop_s_read: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && is_rd && REQ_ADDR_I == mdrm_pkg::A_LOOP_S
    |=> RSP_DATA_O == $past(MON_I.loop_s))
    else $error("signed monitor wrong");

  // loopback echoes the data without an error
  a_loop_echo: assert property (@(posedge CLK_I) disable iff (!rst_n)
    REQ_VALID_I && !bcast && is_loop |=> RSP_DATA_O == $past(REQ_WDATA_I) && !RSP_EXC_O)
    else $error("loopback wrong");

  // the wearing copy moves only on a saving commit
  a_nv_quiet: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !(REQ_VALID_I && commit_nv) |=> $stable(nv_reg) && !NV_SAVE_O)
    else $error("non-volatile copy moved");
endmodule : mdrm_regmap

// ---- common/mdrm_pkg.sv ----
/*
 * constants, field layouts and carrier types for the drive register map.
 * assumes a single-register request port driven by the serial link logic
 * on the same clock; frame checking and response framing live outside.
 */
package mdrm_pkg;
  localparam logic [7:0]  BCAST_ADDR    = 8'h00;
  localparam logic [7:0]  FN_READ       = 8'h03;
  localparam logic [7:0]  FN_LOOP       = 8'h08;
  localparam logic [7:0]  FN_WRITE      = 8'h10;
  localparam logic [7:0]  EC_FUNC       = 8'h01;
  localparam logic [7:0]  EC_REG        = 8'h02;
  localparam logic [7:0]  EC_DATA       = 8'h21;
  localparam logic [7:0]  EC_MODE       = 8'h22;
  localparam logic [15:0] A_CMD         = 16'h0001;
  localparam logic [15:0] A_REF         = 16'h0002;
  localparam logic [15:0] A_STATE       = 16'h002C;
  localparam logic [15:0] A_PINS        = 16'h002D;
  localparam logic [15:0] A_BIAS        = 16'h002F;
  localparam logic [15:0] A_VBUS        = 16'h0031;
  localparam logic [15:0] A_TORQ        = 16'h0032;
  localparam logic [15:0] A_ID1         = 16'h0034;
  localparam logic [15:0] A_ID2         = 16'h0035;
  localparam logic [15:0] A_LOOP_U      = 16'h0038;
  localparam logic [15:0] A_LOOP_S      = 16'h0039;
  localparam logic [15:0] A_LOOP_OUT    = 16'h003A;
  localparam logic [15:0] A_LINK_ERR    = 16'h003D;
  localparam logic [15:0] A_RPM         = 16'h003E;
  localparam logic [15:0] A_PCT         = 16'h003F;
  localparam logic [15:0] A_COMMIT_NV   = 16'h0900;
  localparam logic [15:0] A_COMMIT_RAM  = 16'h0910;
  localparam logic [15:0] A_PARAM_BASE  = 16'h0100;
  localparam logic [15:0] COMMIT_VALUE  = 16'h0000;
  localparam logic [15:0] CMD_MASK      = 16'h7033;
  localparam logic [15:0] LINK_ERR_MASK = 16'h007B;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam int          B_RUN         = 0;
  localparam int          B_REV         = 1;
  localparam int          B_EXTF        = 4;
  localparam int          B_FRST        = 5;
  localparam int          B_CI5         = 12;
  localparam int          PIN_FAULT     = 7;

  // drive status word, packed from bit F down to bit 0
  typedef struct packed {
    logic comm_timeout, fault, restart, ref_loss, torque_det, keypad_run, keypad_ref;
    logic baseblock, undervolt, ready, freq_det2, freq_det1, user_agree, speed_agree;
    logic zero_speed, running;
  } mdrm_status_t;

  // output terminal levels
  typedef struct packed {
    logic relay_contact_output, photocoupler_output_1, photocoupler_output_2, fault_contact;
  } mdrm_pins_t;

  // monitor words from the drive
  typedef struct packed {
    logic [15:0] bias, vbus, torque, loop_u, loop_s, loop_out, rpm, pct;
  } mdrm_mon_t;

  // link error events, one-cycle pulses
  typedef struct packed {
    logic timeout, framing, overrun, parity, length, crc;
  } mdrm_lerr_t;

  // decoded broadcast command outputs
  typedef struct packed {
    logic       run, reverse, ext_fault, fault_reset;
    logic [2:0] contact_in;
  } mdrm_cmd_t;
endpackage : mdrm_pkg

// ---- verif/mdrm_master_model.sv ----
/*
 * serial master seen from the register map: issues one register request
 * per call as a one-cycle strobe with its qualifiers.
 * assumes the shared 125 mhz clock; frames are already split per register.
 */
`timescale 1ns/100ps
module mdrm_master_model (
  input  wire logic        clk_i,       // shared clock
  output logic             req_valid_o, // request strobe
  output logic [7:0]       req_slave_o, // slave address, zero broadcasts
  output logic [7:0]       req_func_o,  // function code
  output logic [15:0]      req_addr_o,  // register number
  output logic [15:0]      req_wdata_o  // write or echo data
);
  // idle fields start with a non-zero pattern, then carry the complement of the last request, so a stale value cannot pass
  initial begin
    req_valid_o = 1'b0;
    req_slave_o = 8'hA5;
    req_func_o  = 8'h5A;
    req_addr_o  = 16'hFFFF;
    req_wdata_o = 16'hFFFF;
  end

  // one request: raised after an edge, taken at the next, then released
  // broadcasts are sent with slave zero by the caller
  // commits carry zero data and non-volatile ones stay rare
  task automatic send(input logic [7:0]  slave,
                      input logic [7:0]  func,
                      input logic [15:0] addr,
                      input logic [15:0] wdata);
    @(posedge clk_i);
    #1;
    req_valid_o = 1'b1;
    req_slave_o = slave;
    req_func_o  = func;
    req_addr_o  = addr;
    req_wdata_o = wdata;
    @(posedge clk_i);
    #1;
    req_valid_o = 1'b0;
    req_slave_o = ~slave;
    req_func_o  = ~func;
    req_addr_o  = ~addr;
    req_wdata_o = ~wdata;
  endtask : send
endmodule : mdrm_master_model

// ---- verif/mdrm_regmap_bench.sv ----
/*
 * self-checking bench for the drive register map, one task per scenario.
 * assumes the master model drives the request port; the bench drives
 * drive-side levels and checks answers in the cycle after each request.
 */
`timescale 1ns/100ps
module mdrm_regmap_bench;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   req_valid;
  logic [7:0]             req_slave;
  logic [7:0]             req_func;
  logic [15:0]            req_addr;
  logic [15:0]            req_wdata;
  mdrm_pkg::mdrm_status_t status = '0;
  mdrm_pkg::mdrm_pins_t   pins = '0;
  mdrm_pkg::mdrm_mon_t    mon = '0;
  mdrm_pkg::mdrm_lerr_t   lerr = '0;
  logic                   fault_rst = 1'b0;
  logic [7:0]             param_sel = 8'h00;
  logic                   rsp_valid;
  logic                   rsp_exc;
  logic [7:0]             rsp_code;
  logic [15:0]            rsp_data;
  mdrm_pkg::mdrm_cmd_t    cmd;
  logic [15:0]            speed_ref;
  logic                   nv_save;
  logic [15:0]            param_act;
  logic [15:0]            param_nv;
  int                     n_errors = 0;
  int                     n_checks = 0;
  int                     cycles = 0;
  localparam logic [7:0]  SL = 8'h01; // unicast slave address
  localparam logic [7:0]  WR = mdrm_pkg::FN_WRITE;
  localparam logic [7:0]  RD = mdrm_pkg::FN_READ;

  always #4 clk = ~clk;

  mdrm_master_model i_mdrm_master_model (
    .clk_i(clk), .req_valid_o(req_valid), .req_slave_o(req_slave),
    .req_func_o(req_func), .req_addr_o(req_addr), .req_wdata_o(req_wdata));

  mdrm_regmap i_mdrm_regmap (
    .CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(req_valid), .REQ_SLAVE_I(req_slave),
    .REQ_FUNC_I(req_func), .REQ_ADDR_I(req_addr), .REQ_WDATA_I(req_wdata),
    .STATUS_I(status), .PINS_I(pins), .MON_I(mon), .LINK_ERR_I(lerr),
    .FAULT_RESET_I(fault_rst), .PARAM_SEL_I(param_sel), .RSP_VALID_O(rsp_valid),
    .RSP_EXC_O(rsp_exc), .RSP_CODE_O(rsp_code), .RSP_DATA_O(rsp_data), .CMD_O(cmd),
    .SPEED_REF_O(speed_ref), .NV_SAVE_O(nv_save), .PARAM_ACT_O(param_act),
    .PARAM_NV_O(param_nv));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // one request; ex is {error flag, code}; broadcasts must stay silent
  task automatic xfer(input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] ad,
                      input logic [15:0] wd, input logic [8:0] ex, input logic [15:0] rd);
    i_mdrm_master_model.send(sl, fn, ad, wd);
    check({15'h0000, rsp_valid}, {15'h0000, sl != mdrm_pkg::BCAST_ADDR}, "answer");
    if (sl != mdrm_pkg::BCAST_ADDR) begin
      check({7'h00, rsp_exc, rsp_code}, {7'h00, ex}, "code");
      if (!ex[8]) check(rsp_data, rd, "data");
    end
  endtask : xfer

  // command bits, broadcast writes and references act at once
  task automatic t_cmd();
    xfer(SL, WR, mdrm_pkg::A_CMD, 16'hFFFF, 9'h000, 16'hFFFF);
    check({9'h000, cmd}, 16'h007F, "cmd all");
    xfer(SL, RD, mdrm_pkg::A_CMD, 16'h0000, 9'h000, 16'h7033);
    xfer(mdrm_pkg::BCAST_ADDR, WR, mdrm_pkg::A_CMD, 16'h2001, 9'h000, 16'h0000);
    check({9'h000, cmd}, 16'h0042, "cmd bcast");
    xfer(mdrm_pkg::BCAST_ADDR, WR, mdrm_pkg::A_REF, 16'h7530, 9'h000, 16'h0000);
    check(speed_ref, 16'h7530, "ref");
    xfer(SL, RD, mdrm_pkg::A_REF, 16'h0000, 9'h000, 16'h7530);
    $display("t_cmd done");
  endtask : t_cmd

  logic [7:0] bad_fn [4] = '{8'h01, 8'h04, 8'h06, 8'h0F}; // codes that must be refused

  // status, pins and monitors read back; reserved and read-only places
  task automatic t_mon();
    status = 16'hC641;
    pins = 4'hF;
    mon = {16'h0001, 16'h0002, 16'h0003, 16'h03E8, 16'hFC18, 16'h8000, 16'h0007, 16'h0008};
    xfer(SL, RD, mdrm_pkg::A_STATE, 16'h0000, 9'h000, 16'hC641);
    xfer(SL, RD, mdrm_pkg::A_PINS, 16'h0000, 9'h000, 16'h0087);
    xfer(SL, RD, mdrm_pkg::A_LOOP_U, 16'h0000, 9'h000, 16'h03E8);
    xfer(SL, RD, mdrm_pkg::A_LOOP_S, 16'h0000, 9'h000, 16'hFC18);
    xfer(SL, RD, mdrm_pkg::A_LOOP_OUT, 16'h0000, 9'h000, 16'h8000);
    xfer(SL, RD, 16'h002E, 16'h0000, 9'h102, 16'h0000);
    xfer(SL, WR, mdrm_pkg::A_STATE, 16'h1234, 9'h122, 16'h0000);
    xfer(SL, mdrm_pkg::FN_LOOP, 16'h0000, 16'hBEEF, 9'h000, 16'hBEEF);
    foreach (bad_fn[i]) xfer(SL, bad_fn[i], mdrm_pkg::A_STATE, 16'h0000, 9'h101, 16'h0000);
    $display("t_mon done");
  endtask : t_mon

  // link errors stick until a fault reset pulse or a rising command bit 5
  task automatic t_lerr();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      #1;
      lerr = 6'h3F;
      @(posedge clk);
      #1;
      lerr = 6'h00;
      xfer(SL, RD, mdrm_pkg::A_LINK_ERR, 16'h0000, 9'h000, 16'h007B);
      xfer(SL, RD, mdrm_pkg::A_LINK_ERR, 16'h0000, 9'h000, 16'h007B);
      if (k == 0) begin
        fault_rst = 1'b1;
        @(posedge clk);
        #1;
        fault_rst = 1'b0;
      end else begin
        xfer(SL, WR, mdrm_pkg::A_CMD, 16'h0020, 9'h000, 16'h0020);
      end
      xfer(SL, RD, mdrm_pkg::A_LINK_ERR, 16'h0000, 9'h000, 16'h0000);
    end
    $display("t_lerr done");
  endtask : t_lerr

  // pending parameters move to ram only, then to ram and the saved copy
  task automatic t_commit();
    xfer(SL, WR, mdrm_pkg::A_PARAM_BASE, 16'h00A5, 9'h000, 16'h00A5);
    check(param_act, 16'h0000, "pending");
    xfer(SL, WR, mdrm_pkg::A_COMMIT_RAM, mdrm_pkg::COMMIT_VALUE, 9'h000, 16'h0000);
    check(param_act, 16'h00A5, "ram act");
    check({param_nv[14:0], nv_save}, 16'h0000, "ram only");
    xfer(SL, WR, mdrm_pkg::A_PARAM_BASE + 16'h0001, 16'h5A5A, 9'h000, 16'h5A5A);
    xfer(SL, WR, mdrm_pkg::A_COMMIT_NV, mdrm_pkg::COMMIT_VALUE, 9'h000, 16'h0000);
    check({15'h0000, nv_save}, 16'h0001, "nv pulse");
    check(param_nv, 16'h00A5, "nv copy 0");
    param_sel = 8'h01;
    #1;
    check(param_act ^ param_nv, 16'h0000, "nv equal");
    check(param_act, 16'h5A5A, "act 1");
    xfer(SL, WR, mdrm_pkg::A_COMMIT_NV, 16'h0001, 9'h121, 16'h0000);
    xfer(SL, RD, mdrm_pkg::A_COMMIT_NV, 16'h0000, 9'h102, 16'h0000);
    xfer(SL, RD, mdrm_pkg::A_COMMIT_RAM, 16'h0000, 9'h102, 16'h0000);
    $display("t_commit done");
  endtask : t_commit

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_cmd();
    t_mon();
    t_lerr();
    t_commit();
    finish_test();
  end
endmodule : mdrm_regmap_bench
